// >>> core/serial_tx_buffer.v
// Purpose: Small transmit character buffer with registered read data.
// Assumes: Write only when not full, read only when not empty.
// Notes: A flush empties it in one cycle.
`timescale 1ns/1ps
module serial_tx_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH_LOG2 = 2
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire flush_i,
  input wire wr_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire rd_i,
  output reg [WIDTH-1:0] rd_data_o,
  output wire full_o,
  output wire empty_o
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wr_ptr;
  reg [DEPTH_LOG2:0] rd_ptr;

  assign empty_o = (wr_ptr == rd_ptr);
  assign full_o = (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]) &&
    (wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]);

  always @(posedge clk_sys_i) begin
    if (ce_i && wr_i && !full_o && !flush_i) begin
      mem[wr_ptr[DEPTH_LOG2-1:0]] <= wr_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
      rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
      rd_data_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
        rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
      end else begin
        if (wr_i && !full_o) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (rd_i && !empty_o) begin
          rd_data_o <= mem[rd_ptr[DEPTH_LOG2-1:0]];
          rd_ptr <= rd_ptr + 1'b1;
        end
      end
    end
  end
endmodule

// >>> core/uart_status_control.v
// Purpose: Serial port with status and control register, transmitter,
//   receiver, address detection and interrupt logic.
// Assumes: Pins synchronous to clk_sys_i; 8N1 frames; 16x oversampling.
// Notes: Register port is word addressed, read data one cycle later.
`timescale 1ns/1ps
`include "uart_status_control_regs.vh"

// Function
// RULE1 - Enable bit 24 turns automatic address detection on or off.
// RULE2 - Bits 23:16 hold the address character matched while detection is on.
// RULE3 - TX irq select: 10 empty, 01 all sent, 00 slot free; 11 reserved.
// RULE4 - Without infrared, invert bit 13 set gives idle low, clear idle high.
// RULE5 - With infrared, invert set gives encoded idle high, clear idle low.
// RULE6 - Receiver enable bit 12 with module on gives the port the RX pin.
// RULE7 - Break bit 11 sends start, twelve zeros, stop; then hardware clears.
// RULE8 - TX enable bit 10 drives the pin; clearing aborts and flushes buffer.
// RULE9 - Read-only bit 9 is one when the transmit buffer is full.
// RULE10 - Bits 31 to 25 read as zero.
// RULE11 - Software never writes code 11 into the TX irq select field.
// RULE12 - Overrun flag sets when a character meets a full receive buffer.
// RULE13 - Shift-empty reads one when idle; receive-idle reads one when idle.
module uart_status_control #(
  parameter TX_DEPTH_LOG2 = 2,
  parameter OVERSAMPLE = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rd_data_o,
  input wire rx_pin_i,
  output reg tx_pin_o,
  output wire tx_pin_oe_o,
  output wire rx_pin_owned_o,
  output wire irq_o
);
  localparam S_IDLE = 4'h1;
  localparam S_START = 4'h2;
  localparam S_DATA = 4'h4;
  localparam S_STOP = 4'h8;
  // Counts are cut to the 4-bit oversample counters on purpose.
  localparam integer OS_LAST = OVERSAMPLE - 1;
  localparam integer OS_MID = OVERSAMPLE / 2 - 1;

  reg auto_addr_detect_enable;
  reg [7:0] addr_char;
  reg [1:0] tx_irq_select;
  reg tx_polarity_invert;
  reg rx_enable_bit;
  reg tx_break_request;
  reg tx_enable_bit;
  reg [1:0] rx_irq_select;
  reg address_char_detect;
  reg framing_error_flag;
  reg rx_overrun_flag;
  reg module_on;
  reg infrared_encode_enable;
  reg [15:0] baud_div;
  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_mask;
  reg [7:0] rx_data;
  reg rx_data_available;

  wire tx_on = module_on && tx_enable_bit;
  wire rx_on = module_on && rx_enable_bit;
  wire tx_flush = !tx_on;
  wire buf_full;
  wire buf_empty;
  wire [7:0] buf_data;
  reg buf_rd;
  wire buf_wr = wr_i && (addr_i == `ADDR_TX_DATA);

  // RULE8 buffer flush
  serial_tx_buffer #(
    .WIDTH(8),
    .DEPTH_LOG2(TX_DEPTH_LOG2)
  ) u_tx_buffer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .flush_i(tx_flush),
    .wr_i(buf_wr),
    .wr_data_i(wr_data_i[7:0]),
    .rd_i(buf_rd),
    .rd_data_o(buf_data),
    .full_o(buf_full),
    .empty_o(buf_empty)
  );

  // Baud tick, shared by transmitter and receiver at 16x rate.
  reg [15:0] baud_cnt;
  wire baud_tick = (baud_cnt == 16'h0000);
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      baud_cnt <= 16'h0000;
    end else if (ce_i) begin
      baud_cnt <= baud_tick ? baud_div : baud_cnt - 16'h0001;
    end
  end

  // Transmitter.
  reg [3:0] tx_state;
  reg [3:0] tx_os;
  reg [3:0] tx_bits;
  reg [7:0] tx_shift;
  reg tx_is_break;
  reg tx_level;
  reg tx_load;
  reg tx_done_pulse;
  wire tx_shift_empty = (tx_state == S_IDLE) && !tx_load;
  wire tx_bit_end = baud_tick && (tx_os == OS_LAST[3:0]);

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_state <= S_IDLE;
      tx_os <= 4'h0;
      tx_bits <= 4'h0;
      tx_shift <= 8'h00;
      tx_is_break <= 1'b0;
      tx_level <= 1'b1;
      tx_load <= 1'b0;
      buf_rd <= 1'b0;
      tx_done_pulse <= 1'b0;
    end else if (ce_i) begin
      buf_rd <= 1'b0;
      tx_done_pulse <= 1'b0;
      if (!tx_on) begin
        // RULE8 abort transfer
        tx_state <= S_IDLE;
        tx_load <= 1'b0;
        tx_level <= 1'b1;
      end else begin
        case (tx_state)
          S_IDLE: begin
            tx_level <= 1'b1;
            // Buffer read data arrive a cycle after buf_rd, so wait.
            if (tx_load && !buf_rd) begin
              tx_load <= 1'b0;
              tx_shift <= buf_data;
              tx_is_break <= tx_break_request;
              tx_state <= S_START;
              tx_os <= 4'h0;
            end else if (!buf_empty && !tx_load) begin
              buf_rd <= 1'b1;
              tx_load <= 1'b1;
            end
          end
          S_START: begin
            tx_level <= 1'b0;
            if (baud_tick) begin
              tx_os <= tx_os + 4'h1;
            end
            if (tx_bit_end) begin
              tx_state <= S_DATA;
              tx_bits <= 4'h0;
            end
          end
          S_DATA: begin
            // RULE7 twelve zero bits
            tx_level <= tx_is_break ? 1'b0 : tx_shift[0];
            if (baud_tick) begin
              tx_os <= tx_os + 4'h1;
            end
            if (tx_bit_end) begin
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits == (tx_is_break ? `BREAK_ZERO_BITS - 4'h1 :
                  `DATA_BITS - 4'h1)) begin
                tx_state <= S_STOP;
              end
            end
          end
          S_STOP: begin
            tx_level <= 1'b1;
            if (baud_tick) begin
              tx_os <= tx_os + 4'h1;
            end
            if (tx_bit_end) begin
              tx_state <= S_IDLE;
              tx_done_pulse <= 1'b1;
            end
          end
          default: begin
            tx_state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // RULE4 RULE5 idle polarity
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_pin_o <= 1'b1;
    end else if (ce_i) begin
      if (infrared_encode_enable) begin
        // Encoded output pulses on zero bits, otherwise rests at idle.
        tx_pin_o <= tx_polarity_invert ^ (!tx_level && tx_os[3]);
      end else begin
        tx_pin_o <= tx_level ^ tx_polarity_invert;
      end
    end
  end
  // RULE8 pin ownership
  assign tx_pin_oe_o = tx_on;
  // RULE6 rx pin ownership
  assign rx_pin_owned_o = rx_on;

  // Receiver, sampling mid-bit.
  reg [3:0] rx_state;
  reg [3:0] rx_os;
  reg [3:0] rx_bits;
  reg [7:0] rx_shift;
  wire rx_in = rx_on ? rx_pin_i : 1'b1;
  wire rx_mid = baud_tick && (rx_os == OS_MID[3:0]);
  wire rx_end = baud_tick && (rx_os == OS_LAST[3:0]);
  wire rx_idle_flag = (rx_state == S_IDLE);
  reg rx_char_pulse;
  reg rx_framing_error_flag_pulse;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_state <= S_IDLE;
      rx_os <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      rx_char_pulse <= 1'b0;
      rx_framing_error_flag_pulse <= 1'b0;
    end else if (ce_i) begin
      rx_char_pulse <= 1'b0;
      rx_framing_error_flag_pulse <= 1'b0;
      if (baud_tick && rx_state != S_IDLE) begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_state)
        S_IDLE: begin
          if (!rx_in) begin
            rx_state <= S_START;
            rx_os <= 4'h0;
          end
        end
        S_START: begin
          if (rx_mid && rx_in) begin
            rx_state <= S_IDLE;
          end else if (rx_end) begin
            rx_state <= S_DATA;
            rx_bits <= 4'h0;
          end
        end
        S_DATA: begin
          if (rx_mid) begin
            rx_shift <= {rx_in, rx_shift[7:1]};
          end
          if (rx_end) begin
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == `DATA_BITS - 4'h1) begin
              rx_state <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_mid) begin
            rx_state <= S_IDLE;
            rx_char_pulse <= 1'b1;
            rx_framing_error_flag_pulse <= !rx_in;
          end
        end
        default: begin
          rx_state <= S_IDLE;
        end
      endcase
    end
  end

  // RULE1 RULE2 address match
  wire addr_hit = (rx_shift == addr_char);
  wire rx_accept = rx_char_pulse && (!auto_addr_detect_enable || addr_hit ||
    address_char_detect);
  // RULE12 overrun detect
  wire overrun_evt = rx_accept && rx_data_available;
  wire rx_read = rd_i && (addr_i == `ADDR_RX_DATA);

  // RULE3 tx irq select
  reg tx_irq_cond;
  always @* begin
    case (tx_irq_select)
      `TXISEL_EMPTY: tx_irq_cond = buf_empty;
      `TXISEL_DONE: tx_irq_cond = tx_done_pulse && buf_empty;
      `TXISEL_FREE: tx_irq_cond = !buf_full;
      default: tx_irq_cond = 1'b0;
    endcase
  end

  wire [`IRQ_WIDTH-1:0] irq_events = {
    rx_char_pulse && auto_addr_detect_enable && addr_hit,
    rx_framing_error_flag_pulse,
    overrun_evt,
    rx_accept,
    tx_irq_cond && tx_on
  };
  assign irq_o = |(irq_status & irq_mask);

  wire wr_sta = wr_i && (addr_i == `ADDR_STATUS_CONTROL);

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      auto_addr_detect_enable <= 1'b0;
      addr_char <= 8'h00;
      tx_irq_select <= `TXISEL_FREE;
      tx_polarity_invert <= 1'b0;
      rx_enable_bit <= 1'b0;
      tx_break_request <= 1'b0;
      tx_enable_bit <= 1'b0;
      rx_irq_select <= 2'h0;
      address_char_detect <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      module_on <= 1'b0;
      infrared_encode_enable <= 1'b0;
      baud_div <= `BAUD_RESET;
      irq_status <= {`IRQ_WIDTH{1'b0}};
      irq_mask <= {`IRQ_WIDTH{1'b0}};
      rx_data <= 8'h00;
      rx_data_available <= 1'b0;
    end else if (ce_i) begin
      if (wr_sta) begin
        auto_addr_detect_enable <= wr_data_i[`BIT_AUTO_ADDR_DETECT_ENABLE];
        addr_char <= wr_data_i[`ADDR_HI:`ADDR_LO];
        tx_irq_select <= wr_data_i[`TXISEL_HI:`TXISEL_LO];
        tx_polarity_invert <= wr_data_i[`BIT_TXINV];
        rx_enable_bit <= wr_data_i[`BIT_RXEN];
        tx_enable_bit <= wr_data_i[`BIT_TXEN];
        rx_irq_select <= wr_data_i[`RXISEL_HI:`RXISEL_LO];
        address_char_detect <= wr_data_i[`BIT_ADDRESS_CHAR_DETECT];
        framing_error_flag <= wr_data_i[`BIT_FRAMING_ERROR_FLAG];
      end
      // RULE7 hardware clear
      if (tx_done_pulse && tx_is_break) begin
        tx_break_request <= 1'b0;
      end else if (wr_sta) begin
        tx_break_request <= wr_data_i[`BIT_TXBRK];
      end
      // RULE12 sticky overrun
      if (overrun_evt) begin
        rx_overrun_flag <= 1'b1;
      end else if (wr_sta) begin
        rx_overrun_flag <= wr_data_i[`BIT_RX_OVERRUN_FLAG];
      end
      if (rx_framing_error_flag_pulse) begin
        framing_error_flag <= 1'b1;
      end
      if (wr_i && addr_i == `ADDR_MODE) begin
        module_on <= wr_data_i[`MODE_BIT_ON];
        infrared_encode_enable <= wr_data_i[`MODE_BIT_INFRARED_ENCODE_ENABLE];
      end
      if (wr_i && addr_i == `ADDR_BAUD) begin
        baud_div <= wr_data_i[15:0];
      end
      if (wr_i && addr_i == `ADDR_IRQ_MASK) begin
        irq_mask <= wr_data_i[`IRQ_WIDTH-1:0];
      end
      // Events win over a write-one-to-clear in the same cycle.
      irq_status <= (irq_status & ~((wr_i && addr_i == `ADDR_IRQ_STATUS) ?
        wr_data_i[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}})) | irq_events;
      // Overrun keeps the older character; the new one is dropped.
      if (rx_accept && !rx_data_available) begin
        rx_data <= rx_shift;
        rx_data_available <= 1'b1;
      end else if (rx_read) begin
        rx_data_available <= 1'b0;
      end
    end
  end

  // RULE9 RULE10 RULE13 status readback
  wire [31:0] sta_word = {7'h00, auto_addr_detect_enable, addr_char, tx_irq_select,
    tx_polarity_invert, rx_enable_bit, tx_break_request, tx_enable_bit,
    buf_full, tx_shift_empty, rx_irq_select, address_char_detect,
    rx_idle_flag, 1'b0, framing_error_flag, rx_overrun_flag,
    rx_data_available};

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_data_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `ADDR_STATUS_CONTROL: rd_data_o <= sta_word;
          `ADDR_MODE: rd_data_o <= {16'h0000, module_on, 2'h0,
            infrared_encode_enable, 12'h000};
          `ADDR_RX_DATA: rd_data_o <= {24'h00_0000, rx_data};
          `ADDR_IRQ_STATUS: rd_data_o <= {27'h000_0000, irq_status};
          `ADDR_IRQ_MASK: rd_data_o <= {27'h000_0000, irq_mask};
          `ADDR_BAUD: rd_data_o <= {16'h0000, baud_div};
          default: rd_data_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// >>> include/uart_status_control_regs.vh
// Purpose: Register offsets, field positions and constants of the serial port.
// Assumes: Word addressed register port, one 32-bit word per register.
// Notes: Included by one core file and two of the bench files.
`ifndef UART_STATUS_CONTROL_REGS_VH
`define UART_STATUS_CONTROL_REGS_VH

`define ADDR_STATUS_CONTROL 4'h0
`define ADDR_MODE 4'h1
`define ADDR_TX_DATA 4'h2
`define ADDR_RX_DATA 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_BAUD 4'h6

`define BIT_AUTO_ADDR_DETECT_ENABLE 24
`define ADDR_HI 23
`define ADDR_LO 16
`define TXISEL_HI 15
`define TXISEL_LO 14
`define BIT_TXINV 13
`define BIT_RXEN 12
`define BIT_TXBRK 11
`define BIT_TXEN 10
`define BIT_TXBF 9
`define BIT_TX_SHIFT_EMPTY 8
`define RXISEL_HI 7
`define RXISEL_LO 6
`define BIT_ADDRESS_CHAR_DETECT 5
`define BIT_RX_IDLE_FLAG 4
`define BIT_FRAMING_ERROR_FLAG 2
`define BIT_RX_OVERRUN_FLAG 1
`define BIT_RX_DATA_AVAILABLE 0

`define MODE_BIT_ON 15
`define MODE_BIT_INFRARED_ENCODE_ENABLE 12

`define TXISEL_FREE 2'h0
`define TXISEL_DONE 2'h1
`define TXISEL_EMPTY 2'h2

`define IRQ_TX 0
`define IRQ_RX 1
`define IRQ_OVERRUN 2
`define IRQ_FRAMING 3
`define IRQ_ADDR_MATCH 4
`define IRQ_WIDTH 5

`define BREAK_ZERO_BITS 4'hC
`define DATA_BITS 4'h8
`define BAUD_RESET 16'h0014

`endif

// >>> verification/serial_peer_model.sv
// Purpose: Remote serial transceiver facing the port's two lines.
// Assumes: 8N1 frames, LSB first, BIT_CYC clock cycles a bit.
// Notes: The receive line rests at the stop level between frames.
`timescale 1ns/1ps
module serial_peer_model #(
  parameter BIT_CYC = 16
) (
  input wire clk_sys_i,
  input wire tx_line_i,
  output reg rx_line_o,
  output reg [7:0] got_o
);
  integer i;
  initial begin
    rx_line_o = 1'b1;
    got_o = 8'h00;
  end
  task send(input [7:0] b);
    reg [9:0] frame;
    integer k;
    begin
      frame = {1'b1, b, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge clk_sys_i);
        rx_line_o <= frame[k];
        repeat (BIT_CYC - 1) @(posedge clk_sys_i);
      end
    end
  endtask
  // Sampling mid-bit keeps a cycle of skew from flipping a bit.
  always begin
    @(negedge tx_line_i);
    repeat (BIT_CYC / 2) @(posedge clk_sys_i);
    for (i = 0; i < 8; i = i + 1) begin
      repeat (BIT_CYC) @(posedge clk_sys_i);
      got_o[i] <= tx_line_i;
    end
    repeat (BIT_CYC) @(posedge clk_sys_i);
  end
endmodule

// >>> verification/uart_status_control_assertions.sv
// Purpose: Temporal checks on the serial port pins and register port.
// Assumes: One clock domain, synchronous active-high reset, ce_i honoured.
// Notes: Shadows of mode, baud and polarity follow the bus writes.
`timescale 1ns/1ps
`include "uart_status_control_regs.vh"
module uart_status_control_assertions #(
  parameter TX_DEPTH_LOG2 = 2,
  parameter OVERSAMPLE = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rd_data_o,
  input wire rx_pin_i,
  input wire tx_pin_o,
  input wire tx_pin_oe_o,
  input wire rx_pin_owned_o,
  input wire irq_o
);
  reg [15:0] mode_q;
  reg inv_q;
  reg [15:0] baud_q;
  reg [31:0] low_cnt;
  wire st_wr = wr_i && ce_i && addr_i == `ADDR_STATUS_CONTROL;
  wire md_wr = wr_i && ce_i && addr_i == `ADDR_MODE;
  wire [31:0] bit_len = OVERSAMPLE * (baud_q + 32'd1);
  // Inverted plain or non-inverted encoded idle levels sit low for ever, so only plain counts.
  wire plain = tx_pin_oe_o && !inv_q && !mode_q[`MODE_BIT_INFRARED_ENCODE_ENABLE];
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_q <= 16'h0000;
      inv_q <= 1'b0;
      baud_q <= `BAUD_RESET;
    end else begin
      if (md_wr)
        mode_q <= wr_data_i[15:0];
      if (st_wr)
        inv_q <= wr_data_i[`BIT_TXINV];
      if (wr_i && ce_i && addr_i == `ADDR_BAUD)
        baud_q <= wr_data_i[15:0];
    end
    low_cnt <= (plain && !tx_pin_o && !rst_i) ? low_cnt + 32'd1 : 32'd0;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_reset_pins;
    disable iff (1'b0) rst_i |=> !tx_pin_oe_o && !rx_pin_owned_o && !irq_o
      && tx_pin_o && rd_data_o == 32'h0000_0000;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("reset pins");
  property p_rd_hi;
    rd_i && ce_i && addr_i == `ADDR_STATUS_CONTROL
      |=> rd_data_o[31:25] == 7'h00;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high bits set");
  property p_tx_off;
    st_wr && !wr_data_i[`BIT_TXEN] |=> !tx_pin_oe_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx still driven");
  property p_tx_on;
    st_wr && wr_data_i[`BIT_TXEN] && mode_q[`MODE_BIT_ON] |=> tx_pin_oe_o;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx not driven");
  property p_rx_off;
    st_wr && !wr_data_i[`BIT_RXEN] |=> !rx_pin_owned_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx still owned");
  property p_rx_on;
    st_wr && wr_data_i[`BIT_RXEN] && mode_q[`MODE_BIT_ON] |=> rx_pin_owned_o;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("rx not owned");
  property p_mode_off;
    md_wr && !wr_data_i[`MODE_BIT_ON] |=> !tx_pin_oe_o && !rx_pin_owned_o;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("pins kept");
  property p_irq_mask;
    wr_i && ce_i && addr_i == `ADDR_IRQ_MASK && wr_data_i[4:0] == 5'h00
      |=> !irq_o [*2];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  property p_break_len;
    low_cnt <= 32'd13 * bit_len;
  endproperty
  a_break_len: assert property (p_break_len)
    else $error("low too long");
  c_break: cover property (low_cnt > 32'd12 * bit_len);
  c_irq: cover property ($rose(irq_o));
  c_rx_own: cover property ($rose(rx_pin_owned_o));
endmodule
bind uart_status_control uart_status_control_assertions #(
  .TX_DEPTH_LOG2(TX_DEPTH_LOG2), .OVERSAMPLE(OVERSAMPLE)
) uart_status_control_assertions_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
  .rx_pin_owned_o(rx_pin_owned_o), .irq_o(irq_o)
);

// >>> verification/uart_status_control_tb_top.sv
// Purpose: Register and pin level tests of the serial status and control.
// Assumes: Baud divider zero, so a bit lasts OVERSAMPLE clock cycles.
// Notes: The peer model plays the remote end of both serial lines.
`timescale 1ns/1ps
`include "uart_status_control_regs.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  n_fail = n_fail + 1; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, g, e); end end
module uart_status_control_tb_top;
  localparam OVS = 16;
  localparam ST = `ADDR_STATUS_CONTROL;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg ce_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [31:0] wr_data_i = 32'h0000_0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [31:0] d;
  wire [31:0] rd_data_o;
  wire [7:0] got;
  wire rx_pin_i, tx_pin_o, tx_pin_oe_o, rx_pin_owned_o, irq_o;
  integer n_fail = 0;
  integer compares = 0;
  integer k;
  integer n;
  always #25 clk_sys_i = ~clk_sys_i;
  uart_status_control #(.TX_DEPTH_LOG2(2), .OVERSAMPLE(OVS))
    uart_status_control_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
    .rx_pin_owned_o(rx_pin_owned_o), .irq_o(irq_o));
  serial_peer_model #(.BIT_CYC(OVS)) serial_peer_model_i (
    .clk_sys_i(clk_sys_i), .tx_line_i(tx_pin_o), .rx_line_o(rx_pin_i),
    .got_o(got));
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      // Let the write settle before the caller looks at the pins.
      #1;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
    end
  endtask
  task chk(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      rd(a);
      `CHK(d & m, e)
    end
  endtask
  // The first character moves to the shifter before the other four land.
  task fill;
    begin
      wr(`ADDR_TX_DATA, 32'h0000_0040);
      repeat (4) @(posedge clk_sys_i);
      for (n = 1; n < 5; n = n + 1)
        wr(`ADDR_TX_DATA, 32'h0000_0040 + n);
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #2_000_000;
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk(ST, 32'hFFFF_FFFF, 32'h0000_0110);
    chk(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(ST, 32'hFFFF_0000);
    chk(ST, 32'hFFFF_FFFF, 32'h01FF_0110);
    // A write while the clock enable is low must leave the register alone.
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(ST, 32'h0000_0000);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    chk(ST, 32'hFFFF_FFFF, 32'h01FF_0110);
    wr(`ADDR_BAUD, 32'h0000_0000);
    wr(`ADDR_MODE, 32'h0000_8000);
    wr(ST, 32'h0000_0400);
    serial_peer_model_i.send(8'h77);
    chk(ST, 32'h0000_1001, 32'h0000_0000);
    `CHK(rx_pin_owned_o, 1'b0)
    wr(ST, 32'h015A_1400);
    `CHK(rx_pin_owned_o, 1'b1)
    `CHK(tx_pin_oe_o, 1'b1)
    serial_peer_model_i.send(8'h11);
    chk(ST, 32'h0000_0001, 32'h0000_0000);
    serial_peer_model_i.send(8'h5A);
    chk(ST, 32'h0000_0001, 32'h0000_0001);
    chk(`ADDR_RX_DATA, 32'h0000_00FF, 32'h0000_005A);
    wr(ST, 32'h0000_1400);
    fork
      serial_peer_model_i.send(8'h33);
      begin
        repeat (3 * OVS) @(posedge clk_sys_i);
        chk(ST, 32'h0000_0010, 32'h0000_0000);
      end
    join
    chk(`ADDR_RX_DATA, 32'h0000_00FF, 32'h0000_0033);
    for (k = 0; k < 6; k = k + 1)
      serial_peer_model_i.send(k[7:0]);
    chk(ST, 32'h0000_0002, 32'h0000_0002);
    rd(`ADDR_RX_DATA);
    chk(ST, 32'h0000_0002, 32'h0000_0002);
    wr(ST, 32'h0000_1400);
    chk(ST, 32'h0000_0002, 32'h0000_0000);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`ADDR_MODE, {16'h0000, 3'h4, k[1], 12'h000});
      wr(ST, {18'h0_0000, k[0], 13'h0400});
      repeat (3) @(posedge clk_sys_i);
      `CHK(tx_pin_o, ~(k[0] ^ k[1]))
    end
    wr(`ADDR_MODE, 32'h0000_8000);
    wr(`ADDR_IRQ_MASK, 32'h0000_0001);
    // The idle-low steps start a false frame in the peer; let it finish.
    repeat (12 * OVS) @(posedge clk_sys_i);
    // Codes 00, 01 and 10 only; 11 is never programmed.
    for (k = 0; k < 3; k = k + 1) begin
      wr(ST, {16'h0000, k[1:0], 14'h1400});
      fill;
      chk(ST, 32'h0000_0200, 32'h0000_0200);
      wr(`ADDR_IRQ_STATUS, 32'h0000_0001);
      chk(`ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0000);
      repeat (60 * OVS) @(posedge clk_sys_i);
      chk(`ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      `CHK(irq_o, 1'b1)
      `CHK(got, 8'h44)
    end
    wr(`ADDR_IRQ_MASK, 32'h0000_0000);
    `CHK(irq_o, 1'b0)
    fill;
    wr(ST, 32'h0000_1000);
    `CHK(tx_pin_oe_o, 1'b0)
    chk(ST, 32'h0000_0300, 32'h0000_0100);
    wr(ST, 32'h0000_1C00);
    wr(`ADDR_TX_DATA, 32'h0000_00FF);
    n = 0;
    while (tx_pin_o === 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n = n + 1;
    end
    n = 0;
    while (tx_pin_o === 1'b0 && n < 400) begin
      @(posedge clk_sys_i);
      #1;
      n = n + 1;
    end
    `CHK(n, 13 * OVS)
    repeat (30 * OVS) @(posedge clk_sys_i);
    chk(ST, 32'h0000_0800, 32'h0000_0000);
    wr(`ADDR_MODE, 32'h0000_0000);
    `CHK({tx_pin_oe_o, rx_pin_owned_o}, 2'b00)
    end_of_test;
  end
endmodule
